// ===== hw/tbp_pkg.sv
package tbp_pkg;

    // register indexes; byte address is four times the index
    localparam logic [15:0] TBP_IDX_LATCH = 16'hffd5;
    localparam logic [15:0] TBP_IDX_DIR   = 16'hffe5;
    localparam logic [15:0] TBP_IDX_FSEL  = 16'hffff;
    localparam logic [15:0] TBP_IDX_SCTL  = 16'hffa8;
    localparam logic [15:0] TBP_IDX_SMODE = 16'hffa9;

    // values after reset
    localparam logic [7:0] TBP_LATCH_RST = 8'h00;
    localparam logic [7:0] TBP_DIR_RST   = 8'h00;
    localparam logic [7:0] TBP_FSEL_RST  = 8'hf8;
    localparam logic [7:0] TBP_SCTL_RST  = 8'h00;
    localparam logic [7:0] TBP_SMODE_RST = 8'h00;

    // the direction register always reads as all ones
    localparam logic [7:0] TBP_DIR_READ = 8'hff;

    // field positions
    localparam int TBP_FSEL_TXD_BIT  = 2;
    localparam int TBP_FSEL_POF_BIT  = 0;
    localparam int TBP_SCTL_RE_BIT   = 4;
    localparam int TBP_SCTL_CLOCK_SELECT_HIGH_BIT = 1;
    localparam int TBP_SCTL_CLOCK_SELECT_LOW_BIT = 0;
    localparam int TBP_SMODE_COM_BIT = 7;

    // pin numbers
    localparam int TBP_NPINS   = 3;
    localparam int TBP_PIN_TXD = 2;
    localparam int TBP_PIN_RXD = 1;
    localparam int TBP_PIN_SCK = 0;

    // bus answers
    localparam logic [1:0] TBP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TBP_RESP_SLVERR = 2'h2;

    // chip operating modes
    typedef enum logic [2:0] {
        TBP_PM_ACTIVE    = 3'b000,
        TBP_PM_SUBACTIVE = 3'b001,
        TBP_PM_SLEEP     = 3'b010,
        TBP_PM_SUBSLEEP  = 3'b011,
        TBP_PM_WATCH     = 3'b100,
        TBP_PM_STANDBY   = 3'b101
    } tbp_pmode_t;

    // pin function selection bits
    typedef struct packed {
        logic txd_sel;
        logic rx_en;
        logic clock_select_high;
        logic clock_select_low;
        logic synchronous_mode_select;
    } tbp_pin_cfg_t;

    // register write handed from the bus slave
    typedef struct packed {
        logic        en;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } tbp_wr_req_t;

    // word address match against a register index
    function automatic logic tbp_hit(input logic [31:0] addr, input logic [15:0] idx);
        return addr == {14'h0, idx, 2'h0};
    endfunction

endpackage

// ===== hw/tbp_axil_slave.sv
`timescale 1ns/1ps
module tbp_axil_slave
    import tbp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output tbp_wr_req_t      wr_req,
    input  wire logic        wr_ok,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    logic        aw_held_reg, w_held_reg, aw_held_next, w_held_next;
    logic [31:0] awaddr_reg, wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_next, rvalid_next;
    logic        aw_take, w_take, ar_take, wr_fire;

    assign aw_take = awvalid & awready;
    assign w_take  = wvalid & wready;
    assign ar_take = arvalid & arready;
    // write fires once both halves are held and the last answer is gone
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid;
    assign wr_req  = '{en: wr_fire, addr: awaddr_reg, data: wdata_reg, strb: wstrb_reg};

    assign aw_held_next = ~wr_fire & (aw_held_reg | aw_take);
    assign w_held_next  = ~wr_fire & (w_held_reg | w_take);
    assign bvalid_next  = wr_fire | (bvalid & ~bready);
    assign rvalid_next  = ar_take | (rvalid & ~rready);

    // readies are registered so the top sees them straight from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            arready     <= 1'b0;
            rvalid      <= 1'b0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg  <= w_held_next;
            awready     <= ~aw_held_next & ~bvalid_next;
            wready      <= ~w_held_next & ~bvalid_next;
            bvalid      <= bvalid_next;
            arready     <= ~rvalid_next;
            rvalid      <= rvalid_next;
        end
    end

    // payload capture and answers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awaddr_reg <= 32'h0;
            wdata_reg  <= 32'h0;
            wstrb_reg  <= 4'h0;
            bresp      <= TBP_RESP_OKAY;
            rdata      <= 32'h0;
            rresp      <= TBP_RESP_OKAY;
        end else begin
            if (aw_take) awaddr_reg <= awaddr;
            if (w_take) begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (wr_fire) bresp <= wr_ok ? TBP_RESP_OKAY : TBP_RESP_SLVERR;
            if (ar_take) begin
                rdata <= rd_ok ? rd_data : 32'h0;
                rresp <= rd_ok ? TBP_RESP_OKAY : TBP_RESP_SLVERR;
            end
        end
    end

endmodule // tbp_axil_slave

// ===== hw/tbp_pin_mux.sv
`timescale 1ns/1ps
module tbp_pin_mux
    import tbp_pkg::*;
(
    input  tbp_pin_cfg_t     cfg,
    input  wire logic [2:0]  dir,
    input  wire logic [2:0]  latch,
    input  wire logic        tx_data,
    input  wire logic        sck_out,
    output logic [2:0]       out_next,
    output logic [2:0]       oe_next
);
    // general i/o first, then peripheral functions override it
    always_comb begin
        for (int i = 0; i < TBP_NPINS; i++) begin
            out_next[i] = latch[i];
            oe_next[i]  = dir[i];
        end
        if (cfg.txd_sel) begin
            out_next[TBP_PIN_TXD] = tx_data;
            oe_next[TBP_PIN_TXD]  = 1'b1;
        end
        if (cfg.rx_en) begin
            out_next[TBP_PIN_RXD] = 1'b0;
            oe_next[TBP_PIN_RXD]  = 1'b0;
        end
        if (cfg.clock_select_high) begin
            out_next[TBP_PIN_SCK] = 1'b0;
            oe_next[TBP_PIN_SCK]  = 1'b0;
        end else if (cfg.clock_select_low | cfg.synchronous_mode_select) begin
            out_next[TBP_PIN_SCK] = sck_out;
            oe_next[TBP_PIN_SCK]  = 1'b1;
        end
    end

endmodule // tbp_pin_mux

// ===== hw/tbp_port.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module tbp_port
    import tbp_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] AWADDR,
    input  wire logic [2:0]  AWPROT,
    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [31:0] ARADDR,
    input  wire logic [2:0]  ARPROT,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    input  tbp_pmode_t       POWER_MODE,
    input  wire logic        TX_DATA,
    input  wire logic        SCK_OUT,
    output logic             RX_DATA,
    output logic             SCK_IN,
    input  wire logic [2:0]  PIN_IN,
    output logic [2:0]       PIN_OUT,
    output logic [2:0]       PIN_OE
);

    // software state
    logic [2:0]   latch_reg;
    logic [2:0]   dir_reg;
    logic         txd_sel_reg;
    logic         pof_reg;
    logic         rx_en_reg;
    logic         clock_select_high_reg;
    logic         clock_select_low_reg;
    logic         com_reg;

    // pin and serial side flops
    logic         rx_data_reg;
    logic         sck_in_reg;
    logic [2:0]   pin_out_reg;
    logic [2:0]   pin_oe_reg;

    // bus plumbing
    tbp_wr_req_t  wr_req;
    logic         wr_ok;
    logic         wr_lane;
    logic [31:0]  rd_data;
    logic         rd_ok;
    logic [2:0]   rd_pins;
    logic [7:0]   wbyte;

    // pin mux results
    tbp_pin_cfg_t pin_cfg;
    logic [2:0]   mux_out;
    logic [2:0]   mux_oe;

    // protection bits carry no meaning for this port
    logic         prot_unused;
    assign prot_unused = ^{AWPROT, ARPROT};

    tbp_axil_slave u_slave (
        .clk     (CLK),
        .rst_n   (RST_N),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .awaddr  (AWADDR),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .bresp   (BRESP),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .araddr  (ARADDR),
        .rvalid  (RVALID),
        .rready  (RREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .wr_req  (wr_req),
        .wr_ok   (wr_ok),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // only lane 0 carries register data; other lanes are dropped
    assign wbyte   = wr_req.data[7:0];
    assign wr_lane = wr_req.en & wr_req.strb[0];

    // write decode, an unmapped address answers with an error
    always_comb begin
        if (tbp_hit(wr_req.addr, TBP_IDX_LATCH)) begin
            wr_ok = 1'b1;
        end else if (tbp_hit(wr_req.addr, TBP_IDX_DIR)) begin
            wr_ok = 1'b1;
        end else if (tbp_hit(wr_req.addr, TBP_IDX_FSEL)) begin
            wr_ok = 1'b1;
        end else if (tbp_hit(wr_req.addr, TBP_IDX_SCTL)) begin
            wr_ok = 1'b1;
        end else if (tbp_hit(wr_req.addr, TBP_IDX_SMODE)) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // port latch and direction; upper bits are not stored at all
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            latch_reg <= TBP_LATCH_RST[2:0];
            dir_reg   <= TBP_DIR_RST[2:0];
        end else if (wr_lane) begin
            if (tbp_hit(wr_req.addr, TBP_IDX_LATCH)) latch_reg <= wbyte[2:0];
            if (tbp_hit(wr_req.addr, TBP_IDX_DIR)) dir_reg <= wbyte[2:0];
        end
    end

    // function select, serial control and serial mode bits
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            txd_sel_reg <= TBP_FSEL_RST[TBP_FSEL_TXD_BIT];
            pof_reg     <= TBP_FSEL_RST[TBP_FSEL_POF_BIT];
            rx_en_reg   <= TBP_SCTL_RST[TBP_SCTL_RE_BIT];
            clock_select_high_reg    <= TBP_SCTL_RST[TBP_SCTL_CLOCK_SELECT_HIGH_BIT];
            clock_select_low_reg    <= TBP_SCTL_RST[TBP_SCTL_CLOCK_SELECT_LOW_BIT];
            com_reg     <= TBP_SMODE_RST[TBP_SMODE_COM_BIT];
        end else if (wr_lane) begin
            if (tbp_hit(wr_req.addr, TBP_IDX_FSEL)) begin
                txd_sel_reg <= wbyte[TBP_FSEL_TXD_BIT];
                pof_reg     <= wbyte[TBP_FSEL_POF_BIT];
            end
            if (tbp_hit(wr_req.addr, TBP_IDX_SCTL)) begin
                rx_en_reg <= wbyte[TBP_SCTL_RE_BIT];
                clock_select_high_reg  <= wbyte[TBP_SCTL_CLOCK_SELECT_HIGH_BIT];
                clock_select_low_reg  <= wbyte[TBP_SCTL_CLOCK_SELECT_LOW_BIT];
            end
            if (tbp_hit(wr_req.addr, TBP_IDX_SMODE)) com_reg <= wbyte[TBP_SMODE_COM_BIT];
        end
    end

    // output pins show the latch, inputs show the live level
    assign rd_pins = (dir_reg & latch_reg) | (~dir_reg & PIN_IN);

    // read decode; the slave registers this at the address handshake,
    // so the pin level is sampled on that same edge
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0;
        if (tbp_hit(ARADDR, TBP_IDX_LATCH)) begin
            rd_data = {29'h0, rd_pins};
        end else if (tbp_hit(ARADDR, TBP_IDX_DIR)) begin
            rd_data = {24'h0, TBP_DIR_READ};
        end else if (tbp_hit(ARADDR, TBP_IDX_FSEL)) begin
            rd_data = {24'h0, TBP_FSEL_RST[7:3], txd_sel_reg, 1'b0, pof_reg};
        end else if (tbp_hit(ARADDR, TBP_IDX_SCTL)) begin
            rd_data[TBP_SCTL_RE_BIT]   = rx_en_reg;
            rd_data[TBP_SCTL_CLOCK_SELECT_HIGH_BIT] = clock_select_high_reg;
            rd_data[TBP_SCTL_CLOCK_SELECT_LOW_BIT] = clock_select_low_reg;
        end else if (tbp_hit(ARADDR, TBP_IDX_SMODE)) begin
            rd_data[TBP_SMODE_COM_BIT] = com_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    assign pin_cfg = '{txd_sel: txd_sel_reg, rx_en: rx_en_reg, clock_select_high: clock_select_high_reg,
                       clock_select_low: clock_select_low_reg, synchronous_mode_select: com_reg};

    // peripheral assignment overrides latch and direction
    tbp_pin_mux u_mux (
        .cfg      (pin_cfg),
        .dir      (dir_reg),
        .latch    (latch_reg),
        .tx_data  (TX_DATA),
        .sck_out  (SCK_OUT),
        .out_next (mux_out),
        .oe_next  (mux_oe)
    );

    // pin drivers follow the power mode; registering them costs a cycle
    // of latency but keeps glitches off the board
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_out_reg <= 3'h0;
            pin_oe_reg  <= 3'h0;
        end else begin
            case (POWER_MODE)
                TBP_PM_ACTIVE, TBP_PM_SUBACTIVE: begin
                    pin_out_reg <= mux_out;
                    pin_oe_reg  <= mux_oe;
                end
                TBP_PM_STANDBY: begin
                    pin_oe_reg <= 3'h0;
                end
                default: begin
                    pin_oe_reg <= pin_oe_reg;
                end
            endcase
        end
    end

    // serial side inputs; receive idles high so a disabled line looks idle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_data_reg <= 1'b1;
            sck_in_reg  <= 1'b0;
        end else begin
            rx_data_reg <= rx_en_reg ? PIN_IN[TBP_PIN_RXD] : 1'b1;
            sck_in_reg  <= clock_select_high_reg ? PIN_IN[TBP_PIN_SCK] : 1'b0;
        end
    end

    assign PIN_OUT = pin_out_reg;
    assign PIN_OE  = pin_oe_reg;
    assign RX_DATA = rx_data_reg;
    assign SCK_IN  = sck_in_reg;

    // a functional mode, used by the checks below
    logic functional;
    assign functional = (POWER_MODE == TBP_PM_ACTIVE) || (POWER_MODE == TBP_PM_SUBACTIVE);

    latch_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (ARVALID && ARREADY && tbp_hit(ARADDR, TBP_IDX_LATCH))
        |=> RVALID && RDATA[31:3] == 29'h0
            && (RDATA[2:0] & $past(dir_reg)) == ($past(latch_reg) & $past(dir_reg)))
        else $error("latch read returned wrong value");

    pin_sense_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (ARVALID && ARREADY && tbp_hit(ARADDR, TBP_IDX_LATCH) && dir_reg == 3'h0)
        |=> RDATA[2:0] == $past(PIN_IN))
        else $error("input pin level not read back");

    dir_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (ARVALID && ARREADY && tbp_hit(ARADDR, TBP_IDX_DIR))
        |=> RDATA == 32'h0000_00ff && RRESP == TBP_RESP_OKAY)
        else $error("direction read not all ones");

    reset_clear_a: assert property (@(posedge CLK)
        !RST_N |=> latch_reg == 3'h0 && dir_reg == 3'h0 && PIN_OE == 3'h0)
        else $error("reset did not clear port");

    gpio_drive_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (functional && !txd_sel_reg && dir_reg[TBP_PIN_TXD])
        |=> PIN_OE[TBP_PIN_TXD] && PIN_OUT[TBP_PIN_TXD] == $past(latch_reg[TBP_PIN_TXD]))
        else $error("output pin not driving latch");

    write_effect_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_lane && tbp_hit(wr_req.addr, TBP_IDX_DIR) && functional && !txd_sel_reg
         && !rx_en_reg && !clock_select_high_reg && !clock_select_low_reg && !com_reg)
        ##1 functional |=> PIN_OE == $past(dir_reg))
        else $error("direction write not on pins next cycle");

    txd_pin_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (functional && txd_sel_reg)
        |=> PIN_OE[TBP_PIN_TXD] && PIN_OUT[TBP_PIN_TXD] == $past(TX_DATA))
        else $error("transmit pin not driven");

    rx_pin_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (functional && rx_en_reg)
        |=> !PIN_OE[TBP_PIN_RXD] && RX_DATA == $past(PIN_IN[TBP_PIN_RXD]))
        else $error("receive pin not an input");

    sck_in_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (functional && clock_select_high_reg) |=> !PIN_OE[TBP_PIN_SCK] && SCK_IN == $past(PIN_IN[0]))
        else $error("clock pin not an input");

    sck_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (functional && !clock_select_high_reg && (clock_select_low_reg || com_reg))
        |=> PIN_OE[TBP_PIN_SCK] && PIN_OUT[TBP_PIN_SCK] == $past(SCK_OUT))
        else $error("clock pin not driving");

    standby_hiz_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (POWER_MODE == TBP_PM_STANDBY) |=> PIN_OE == 3'h0)
        else $error("pins driven in standby");

    sleep_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (POWER_MODE inside {TBP_PM_SLEEP, TBP_PM_SUBSLEEP, TBP_PM_WATCH})
        |=> $stable(PIN_OE) && $stable(PIN_OUT))
        else $error("pins changed in a hold mode");

endmodule // tbp_port

// ===== verif/tbp_board.sv
`timescale 1ns/1ps
// board logic on the three port pins
module tbp_board (
    input  wire logic       clk,
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    output logic [2:0]      pin_lvl
);
    logic [2:0] last_lvl = 3'h0;

    // a strong board driver wins; a floating pin flips every cycle, so no stale level looks valid
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else pin_lvl[i] = ~last_lvl[i];
        end
    end

    // remember the level for the floating case
    always_ff @(posedge clk) begin
        last_lvl <= pin_lvl;
    end
endmodule // tbp_board

// ===== verif/tb_tbp_port.sv
`timescale 1ns/1ps
module tb_tbp_port
    import tbp_pkg::*;
;
    localparam logic [31:0] A_LATCH = {14'h0, TBP_IDX_LATCH, 2'h0};
    localparam logic [31:0] A_DIR   = {14'h0, TBP_IDX_DIR, 2'h0};
    localparam logic [31:0] A_FSEL  = {14'h0, TBP_IDX_FSEL, 2'h0};
    localparam logic [31:0] A_SCTL  = {14'h0, TBP_IDX_SCTL, 2'h0};
    localparam logic [31:0] A_SMODE = {14'h0, TBP_IDX_SMODE, 2'h0};

    logic        clk = 1'b0, rst_n = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        tx_data = 1'b0, sck_out = 1'b0;
    logic [2:0]  ext_en = 3'h0, ext_val = 3'h0;
    tbp_pmode_t  pmode = TBP_PM_ACTIVE;
    logic        awready, wready, bvalid, arready, rvalid, rx_data, sck_in;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [2:0]  pin_out, pin_oe, pin_in;
    int          miscompares = 0, comparisons = 0;

    tbp_port tbp_port_i (.CLK(clk), .RST_N(rst_n), .AWVALID(awvalid), .AWREADY(awready),
        .AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
        .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
        .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready),
        .RDATA(rdata), .RRESP(rresp), .POWER_MODE(pmode), .TX_DATA(tx_data),
        .SCK_OUT(sck_out), .RX_DATA(rx_data), .SCK_IN(sck_in), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe));

    tbp_board tbp_board_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_lvl(pin_in));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one write; an edge passes first so bready never changes twice in a step
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // wait for the answer however long it takes; only the watchdog ends a hang
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("write answer", 32'h0, {30'h0, awvalid, wvalid});
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk("read answer", 32'h0, {31'h0, arvalid});
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk("read data", exp, d);
        chk("rresp", {30'h0, TBP_RESP_OKAY}, {30'h0, r});
    endtask

    // pins start as inputs, so the board must hold them or the read floats
    task automatic t_reset;
        chk("pin_oe", 32'h0, {29'h0, pin_oe});
        chk("rx_data", 32'h1, {31'h0, rx_data});
        chk("sck_in", 32'h0, {31'h0, sck_in});
        ext_en <= 3'h7;
        ext_val <= 3'h2;
        rchk(A_LATCH, 32'h2);
        rchk(A_DIR, 32'hff);
        rchk(A_FSEL, 32'hf8);
        wr(A_DIR, 32'h7, TBP_RESP_OKAY);
        rchk(A_LATCH, 32'h0);
        wr(A_DIR, 32'h0, TBP_RESP_OKAY);
        ext_en <= 3'h0;
    endtask

    // a board driving against the pins shows where a read takes its value
    task automatic t_drive;
        wr(A_DIR, 32'h7, TBP_RESP_OKAY);
        wr(A_LATCH, 32'hfd, TBP_RESP_OKAY);
        cyc(2);
        chk("pin_oe", 32'h7, {29'h0, pin_oe});
        chk("pin_out", 32'h5, {29'h0, pin_out});
        rchk(A_LATCH, 32'h5);
        ext_en <= 3'h7;
        ext_val <= 3'h2;
        rchk(A_LATCH, 32'h5);
        wr(A_DIR, 32'h0, TBP_RESP_OKAY);
        cyc(2);
        chk("pin_oe", 32'h0, {29'h0, pin_oe});
        rchk(A_LATCH, 32'h2);
        wr(A_DIR, 32'h1, TBP_RESP_OKAY);
        rchk(A_LATCH, 32'h3);
        ext_en <= 3'h0;
    endtask

    // peripheral functions override direction and latch
    task automatic t_serial;
        logic exp_oe;
        wr(A_DIR, 32'h0, TBP_RESP_OKAY);
        wr(A_FSEL, 32'h4, TBP_RESP_OKAY);
        tx_data <= 1'b1;
        cyc(2);
        chk("pin2 oe", 32'h1, {31'h0, pin_oe[2]});
        chk("pin2 out", 32'h1, {31'h0, pin_out[2]});
        tx_data <= 1'b0;
        cyc(2);
        chk("pin2 out", 32'h0, {31'h0, pin_out[2]});
        wr(A_FSEL, 32'h0, TBP_RESP_OKAY);
        wr(A_DIR, 32'h2, TBP_RESP_OKAY);
        wr(A_SCTL, 32'h10, TBP_RESP_OKAY);
        ext_en <= 3'h2;
        ext_val <= 3'h2;
        cyc(2);
        chk("pin1 oe", 32'h0, {31'h0, pin_oe[1]});
        chk("rx_data", 32'h1, {31'h0, rx_data});
        ext_val <= 3'h0;
        cyc(2);
        chk("rx_data", 32'h0, {31'h0, rx_data});
        wr(A_DIR, 32'h0, TBP_RESP_OKAY);
        // every combination of high select, low select and sync mode
        for (int k = 0; k < 8; k++) begin
            wr(A_SCTL, {30'h0, k[2], k[1]}, TBP_RESP_OKAY);
            wr(A_SMODE, {24'h0, k[0], 7'h0}, TBP_RESP_OKAY);
            sck_out <= k[0];
            ext_en <= {2'h0, k[2]};
            ext_val <= 3'h1;
            cyc(2);
            exp_oe = !k[2] && (k[1] || k[0]);
            chk("pin0 oe", {31'h0, exp_oe}, {31'h0, pin_oe[0]});
            if (exp_oe) chk("pin0 out", {31'h0, k[0]}, {31'h0, pin_out[0]});
            chk("sck_in", {31'h0, k[2]}, {31'h0, sck_in});
        end
        wr(A_SCTL, 32'h0, TBP_RESP_OKAY);
        wr(A_SMODE, 32'h0, TBP_RESP_OKAY);
        ext_en <= 3'h0;
    endtask

    task automatic t_power;
        tbp_pmode_t hold_m [3] = '{TBP_PM_SLEEP, TBP_PM_SUBSLEEP, TBP_PM_WATCH};
        wr(A_DIR, 32'h7, TBP_RESP_OKAY);
        wr(A_LATCH, 32'h5, TBP_RESP_OKAY);
        for (int m = 0; m < 3; m++) begin
            pmode <= hold_m[m];
            wr(A_LATCH, 32'h2, TBP_RESP_OKAY);
            cyc(2);
            chk("held pin_out", 32'h5, {29'h0, pin_out});
            chk("held pin_oe", 32'h7, {29'h0, pin_oe});
            pmode <= TBP_PM_ACTIVE;
            cyc(2);
            chk("pin_out", 32'h2, {29'h0, pin_out});
            wr(A_LATCH, 32'h5, TBP_RESP_OKAY);
        end
        pmode <= TBP_PM_STANDBY;
        cyc(2);
        chk("standby pin_oe", 32'h0, {29'h0, pin_oe});
        pmode <= TBP_PM_SUBACTIVE;
        cyc(2);
        chk("pin_oe", 32'h7, {29'h0, pin_oe});
        chk("pin_out", 32'h5, {29'h0, pin_out});
    endtask

    // an unmapped address is refused and changes nothing
    task automatic t_bad;
        logic [31:0] d;
        logic [1:0]  r;
        wr(32'h100, 32'h0, TBP_RESP_SLVERR);
        rd(32'h100, d, r);
        chk("unmapped data", 32'h0, d);
        chk("unmapped rresp", {30'h0, TBP_RESP_SLVERR}, {30'h0, r});
        rchk(A_LATCH, 32'h5);
    endtask

    // main sequence, with a second reset in mid-run
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        t_reset;
        t_drive;
        t_serial;
        t_power;
        t_bad;
        rst_n <= 1'b0;
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        t_reset;
        results;
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        miscompares++;
        results;
    end
endmodule // tb_tbp_port
